// ==== logic/positioning_table_entry_decoder.sv ====
// Table-method positioning sequencer with APB register access
//
// Decided for this implementation: the register offsets and the APB slave port.
`timescale 1ns/100ps
module positioning_table_entry_decoder (
  input  wire logic                       clk_i,
  input  wire logic                       srst_i,
  input  wire table_seq_pkg::apb_req_s    apb_i,
  output logic [31:0]                     prdata_o,
  output logic                            pready_o,
  output logic                            pslverr_o,
  output logic                            cmd_valid_o,
  output table_seq_pkg::motion_cmd_s      cmd_o,
  input  wire table_seq_pkg::motion_rsp_s motion_i,
  output logic                            mcode_active_o
);
  import table_seq_pkg::*;

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  typedef struct packed {
    state_e      st;
    logic [6:0]  ptr;
    logic [1:0]  pre;
    mmode_e      mmode;
    logic [7:0]  mnum;
    logic [7:0]  mpend;
    logic        mcode_active;
    logic        mcode_wait;
    logic        err;
    logic [15:0] err_code;
    logic        done;
    logic        tms;
    logic        manual;
    logic        manual_prev;
    logic [6:0]  start_entry;
    logic        cmd_valid;
    motion_cmd_s cmd;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } state_s;

  state_s      s_q, s_d;
  logic [31:0] tab_q [TABLE_WORDS];
  logic [31:0] par_q [PARAM_COUNT];

  logic        acc, wr, ctrl_wr, start_p, stop_p, mrel_p;
  logic        tab_hit, par_hit, clr_tab, init_par;
  logic [8:0]  widx;
  logic [2:0]  pidx;

  assign acc     = apb_i.psel & apb_i.penable & s_q.pready;
  assign wr      = acc & apb_i.pwrite & ~s_q.pslverr;
  assign ctrl_wr = wr & (apb_i.paddr == CTRL_ADDR);
  assign start_p = ctrl_wr & apb_i.pwdata[CTRL_START_BIT];
  assign stop_p  = ctrl_wr & apb_i.pwdata[CTRL_STOP_BIT];
  assign mrel_p  = ctrl_wr & apb_i.pwdata[CTRL_MREL_BIT];
  assign tab_hit = apb_i.paddr < TABLE_END;
  assign par_hit = apb_i.paddr[11:5] == PARAM_BASE[11:5];
  assign widx    = apb_i.paddr[10:2];
  assign pidx    = apb_i.paddr[4:2];
  assign clr_tab  = s_q.manual & ~s_q.manual_prev & ~s_q.tms;
  assign init_par = ~s_q.manual & s_q.manual_prev & ~s_q.tms;

  // ------------------------------------------------------------------
  // Table and parameter storage
  // ------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (srst_i || clr_tab) begin
      for (int i = 0; i < TABLE_WORDS; i++) begin
        tab_q[i] <= '0;
      end
    end else if (wr && tab_hit) begin
      tab_q[widx] <= apb_i.pwdata;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i || init_par) begin
      for (int i = 0; i < PARAM_COUNT; i++) begin
        par_q[i] <= PARAM_DEFAULT;
      end
    end else if (wr && par_hit) begin
      par_q[pidx] <= apb_i.pwdata;
    end
  end

  // ------------------------------------------------------------------
  // Entry decode
  // ------------------------------------------------------------------
  logic [31:0] e_cmd, e_pos, e_spd, e_m, n_spd, n_m, m_sel;
  logic [6:0]  lo;
  logic [1:0]  pre;
  logic        code_ok, use_pos, use_spd, skip, jog2;
  mmode_e      mm;
  logic [7:0]  mn;

  always_comb begin
    e_cmd = tab_q[{s_q.ptr, FLD_CMD}];
    e_pos = tab_q[{s_q.ptr, FLD_POS}];
    e_spd = tab_q[{s_q.ptr, FLD_SPEED}];
    e_m   = tab_q[{s_q.ptr, FLD_MCODE}];
    n_spd = tab_q[{7'(s_q.ptr + 7'h01), FLD_SPEED}];
    n_m   = tab_q[{7'(s_q.ptr + 7'h01), FLD_MCODE}];
    lo    = 7'h00;
    pre   = 2'h0;
    code_ok = 1'b1;
    if (e_cmd < 32'd100) begin
      lo = e_cmd[6:0];
    end else if (e_cmd < 32'd200) begin
      lo  = 7'(e_cmd - 32'd100);
      pre = 2'h1;
    end else if (e_cmd < 32'd300) begin
      lo  = 7'(e_cmd - 32'd200);
      pre = 2'h2;
    end else begin
      code_ok = 1'b0;
    end
    use_pos = 1'b0;
    use_spd = 1'b0;
    unique case (lo)
      7'd0, 7'd1, 7'd31, 7'd71, 7'd72: begin
        use_pos = 1'b1;
        use_spd = 1'b1;
      end
      7'd4, 7'd73, 7'd92: use_pos = 1'b1;
      7'd9, 7'd28, 7'd29, 7'd30, 7'd76, 7'd90, 7'd91: ;
      default: code_ok = 1'b0;
    endcase
    jog2  = lo == OP_TWO_JOG;
    skip  = lo == OP_FAST_MOVE && e_spd == '0;
    m_sel = jog2 ? n_m : e_m;
    mm    = M_NONE;
    mn    = 8'h00;
    if (m_sel >= 32'd100 && m_sel < 32'd200) begin
      mm = M_WITH;
      mn = 8'(m_sel - 32'd100);
    end else if (m_sel != 32'd0 && m_sel != 32'd2 && m_sel < 32'd100) begin
      mm = M_AFTER;
      mn = m_sel[7:0];
    end
  end

  // ------------------------------------------------------------------
  // Sequencer and register file
  // ------------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.cmd_valid   = 1'b0;
    s_d.pready      = 1'b0;
    s_d.pslverr     = 1'b0;
    s_d.manual_prev = s_q.manual;
    if (apb_i.psel && !apb_i.penable) begin
      s_d.pready = 1'b1;
      s_d.prdata = '0;
      if (tab_hit) begin
        s_d.prdata = tab_q[widx];
      end else if (par_hit) begin
        s_d.prdata = par_q[pidx];
      end else if (apb_i.paddr == CTRL_ADDR) begin
        s_d.prdata[CTRL_MANUAL_BIT] = s_q.manual;
        s_d.prdata[CTRL_TMS_BIT]    = s_q.tms;
      end else if (apb_i.paddr == START_ADDR) begin
        s_d.prdata[6:0] = s_q.start_entry;
      end else if (apb_i.paddr == STATUS_ADDR) begin
        s_d.prdata[5:0] = {s_q.done, s_q.err, s_q.mcode_wait, s_q.mcode_active,
                           s_q.st == ST_HOLD, s_q.st != ST_IDLE};
      end else if (apb_i.paddr == MNUM_ADDR) begin
        s_d.prdata[7:0] = s_q.mnum;
      end else if (apb_i.paddr == ERR_ADDR) begin
        s_d.prdata[15:0] = s_q.err_code;
      end else begin
        s_d.pslverr = 1'b1;
      end
    end
    if (ctrl_wr) begin
      s_d.manual = apb_i.pwdata[CTRL_MANUAL_BIT];
      s_d.tms    = apb_i.pwdata[CTRL_TMS_BIT];
    end
    if (wr && apb_i.paddr == START_ADDR) begin
      s_d.start_entry = apb_i.pwdata[6:0];
    end
    if (mrel_p) begin
      s_d.mcode_active = 1'b0;
      s_d.mcode_wait   = 1'b0;
    end
    unique case (s_q.st)
      ST_IDLE: begin
        if (start_p) begin
          s_d.err  = 1'b0;
          s_d.done = 1'b0;
          if (s_q.start_entry > LAST_ENTRY) begin
            s_d.err      = 1'b1;
            s_d.err_code = ERR_BAD_START;
          end else begin
            s_d.ptr = s_q.start_entry;
            s_d.st  = ST_FETCH;
          end
        end
      end
      ST_FETCH: begin
        s_d.pre   = pre;
        s_d.mmode = mm;
        s_d.mpend = mn;
        if (!code_ok) begin
          s_d.st       = ST_IDLE;
          s_d.err      = 1'b1;
          s_d.err_code = ERR_BAD_CODE;
        end else if (skip) begin
          s_d.pre = 2'h0;
          s_d.st  = ST_NEXT;
        end else if (jog2 && s_q.ptr == LAST_ENTRY) begin
          s_d.st       = ST_IDLE;
          s_d.err      = 1'b1;
          s_d.err_code = ERR_NO_SECOND;
        end else begin
          s_d.cmd.op     = lo;
          s_d.cmd.pos    = use_pos ? e_pos : '0;
          s_d.cmd.speed  = use_spd ? e_spd : '0;
          s_d.cmd.speed2 = jog2 ? n_spd : '0;
          if (jog2) begin
            s_d.ptr = 7'(s_q.ptr + 7'h01);
          end
          s_d.st = ST_ISSUE;
        end
      end
      ST_ISSUE: begin
        s_d.cmd_valid = 1'b1;
        s_d.st        = ST_MOTION;
        if (s_q.mmode == M_WITH) begin
          s_d.mcode_active = 1'b1;
          s_d.mcode_wait   = 1'b1;
          s_d.mnum         = s_q.mpend;
        end
      end
      ST_MOTION: begin
        if (motion_i.err) begin
          s_d.st       = ST_IDLE;
          s_d.err      = 1'b1;
          s_d.err_code = motion_i.code;
        end else if (motion_i.done) begin
          s_d.st = (s_q.mmode == M_NONE) ? ST_NEXT : ST_MCODE;
          if (s_q.mmode == M_AFTER) begin
            s_d.mcode_active = 1'b1;
            s_d.mcode_wait   = 1'b1;
            s_d.mnum         = s_q.mpend;
          end
        end
      end
      ST_MCODE: begin
        if (!s_q.mcode_active) begin
          s_d.st = ST_NEXT;
        end
      end
      ST_NEXT: begin
        if (s_q.pre == 2'h2 || s_q.ptr == LAST_ENTRY) begin
          s_d.st   = ST_IDLE;
          s_d.done = 1'b1;
        end else begin
          s_d.ptr = 7'(s_q.ptr + 7'h01);
          s_d.st  = (s_q.pre == 2'h1) ? ST_HOLD : ST_FETCH;
        end
      end
      ST_HOLD: begin
        if (start_p) begin
          s_d.st = ST_FETCH;
        end
      end
    endcase
    if (stop_p) begin
      s_d.st = ST_IDLE;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      s_q       <= '0;
      s_q.st    <= ST_IDLE;
      s_q.mmode <= M_NONE;
    end else begin
      s_q <= s_d;
    end
  end

  assign prdata_o       = s_q.prdata;
  assign pready_o       = s_q.pready;
  assign pslverr_o      = s_q.pslverr;
  assign cmd_valid_o    = s_q.cmd_valid;
  assign cmd_o          = s_q.cmd;
  assign mcode_active_o = s_q.mcode_active;

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);

  sequence s_after_done;
    s_q.st == ST_MOTION && motion_i.done && !motion_i.err && s_q.mmode == M_AFTER && !stop_p;
  endsequence
  sequence s_flag_held;
    s_q.mcode_active && s_q.mcode_wait && s_q.st == ST_MCODE;
  endsequence

  a_issue_pulse: assert property (s_q.st == ST_ISSUE && !stop_p |=>
    cmd_valid_o && s_q.st == ST_MOTION ##1 !cmd_valid_o)
    else $error("command not issued for one cycle");
  a_skip_zero: assert property (s_q.st == ST_FETCH && code_ok && skip && !stop_p |=>
    s_q.st == ST_NEXT ##1 !cmd_valid_o)
    else $error("zero speed entry not skipped");
  a_bad_code: assert property (s_q.st == ST_FETCH && !code_ok |=>
    s_q.st == ST_IDLE && s_q.err && s_q.err_code == ERR_BAD_CODE)
    else $error("bad code not reported");
  a_end_stops: assert property (s_q.st == ST_NEXT && (s_q.pre == 2'h2 ||
    s_q.ptr == LAST_ENTRY) |=> s_q.st == ST_IDLE && s_q.done)
    else $error("run did not end");
  a_wait_holds: assert property (s_q.st == ST_HOLD && !start_p && !stop_p |=>
    s_q.st == ST_HOLD)
    else $error("left wait without start");
  a_mcode_hold: assert property (s_q.mcode_active && !mrel_p |=>
    s_q.mcode_active)
    else $error("m code flag dropped early");
  a_after_mcode: assert property (s_after_done |=> s_flag_held
    and (s_q.mnum == $past(s_q.mpend)))
    else $error("after mode m code not raised");
  a_with_mcode: assert property (s_q.st == ST_ISSUE && s_q.mmode == M_WITH |=>
    s_q.mcode_active && cmd_valid_o)
    else $error("with mode m code not raised");
  a_clear_table: assert property (clr_tab |=> tab_q[0] == '0 &&
    tab_q[TABLE_WORDS-1] == '0)
    else $error("table not cleared");
  a_keep_mode: assert property (s_q.tms && s_q.manual != s_q.manual_prev && !wr |=>
    tab_q[0] == $past(tab_q[0]) && par_q[0] == $past(par_q[0]))
    else $error("storage touched in table mode");
  a_jog_pair: assert property (s_q.st == ST_FETCH && code_ok && jog2 &&
    s_q.ptr != LAST_ENTRY && !stop_p |=> s_q.ptr == 7'($past(s_q.ptr) + 7'h01))
    else $error("second jog entry not consumed");
endmodule : positioning_table_entry_decoder

// ==== logic/table_seq_pkg.sv ====
// Constants, types and register map of the positioning table sequencer
package table_seq_pkg;
  // ------------------------------------------------------------------
  // Table geometry
  // ------------------------------------------------------------------
  localparam int          ENTRY_COUNT = 100;
  localparam logic [6:0]  LAST_ENTRY  = 7'h63;
  localparam int          TABLE_WORDS = ENTRY_COUNT * 4;
  localparam logic [1:0]  FLD_CMD     = 2'h0;
  localparam logic [1:0]  FLD_POS     = 2'h1;
  localparam logic [1:0]  FLD_SPEED   = 2'h2;
  localparam logic [1:0]  FLD_MCODE   = 2'h3;
  localparam int          PARAM_COUNT = 8;
  localparam logic [31:0] PARAM_DEFAULT = 32'h0000_0064;
  // ------------------------------------------------------------------
  // Byte addresses
  // ------------------------------------------------------------------
  localparam logic [11:0] TABLE_END   = 12'h640;
  localparam logic [11:0] CTRL_ADDR   = 12'h800;
  localparam logic [11:0] START_ADDR  = 12'h804;
  localparam logic [11:0] STATUS_ADDR = 12'h808;
  localparam logic [11:0] MNUM_ADDR   = 12'h80c;
  localparam logic [11:0] ERR_ADDR    = 12'h810;
  localparam logic [11:0] PARAM_BASE  = 12'hc00;
  // ------------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------------
  localparam int CTRL_MANUAL_BIT = 0;
  localparam int CTRL_START_BIT  = 1;
  localparam int CTRL_STOP_BIT   = 2;
  localparam int CTRL_MREL_BIT   = 3;
  localparam int CTRL_TMS_BIT    = 5;
  // ------------------------------------------------------------------
  // Operation codes and errors
  // ------------------------------------------------------------------
  localparam logic [6:0] OP_FAST_MOVE = 7'h00;
  localparam logic [6:0] OP_TWO_JOG   = 7'h48;
  localparam logic [15:0] ERR_BAD_CODE   = 16'h0001;
  localparam logic [15:0] ERR_BAD_START  = 16'h0002;
  localparam logic [15:0] ERR_NO_SECOND  = 16'h0003;
  // ------------------------------------------------------------------
  // Types
  // ------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0, ST_FETCH = 3'h1, ST_ISSUE = 3'h3, ST_MOTION = 3'h2,
    ST_MCODE = 3'h6, ST_NEXT = 3'h7, ST_HOLD = 3'h5
  } state_e;
  typedef enum logic [1:0] {M_NONE = 2'h0, M_AFTER = 2'h1, M_WITH = 2'h2} mmode_e;
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } apb_req_s;
  typedef struct packed {
    logic [6:0]  op;
    logic [31:0] pos;
    logic [31:0] speed;
    logic [31:0] speed2;
  } motion_cmd_s;
  typedef struct packed {
    logic        done;
    logic        err;
    logic [15:0] code;
  } motion_rsp_s;
endpackage : table_seq_pkg

// ==== tb/motion_side_model.sv ====
// Motion-side responder model for the table sequencer
`timescale 1ns/100ps
module motion_side_model (
  input  wire logic                   clk_i,
  input  wire logic                   srst_i,
  input  wire logic                   cmd_valid_i,
  input  wire logic [7:0]             delay_i,
  input  wire logic                   err_en_i,
  input  wire logic [15:0]            err_code_i,
  output table_seq_pkg::motion_rsp_s  motion_o
);
  import table_seq_pkg::*;
  logic       busy_q;
  logic [7:0] cnt_q;
  // ----
  // One done or fault pulse per command, after a set delay
  // ----
  always_ff @(posedge clk_i) begin
    motion_o <= '0;
    if (srst_i) begin
      busy_q <= 1'b0;
      cnt_q  <= 8'h00;
    end else if (cmd_valid_i) begin
      busy_q <= 1'b1;
      cnt_q  <= delay_i;
    end else if (busy_q) begin
      cnt_q <= cnt_q - 8'h01;
      if (cnt_q <= 8'h01) begin
        busy_q        <= 1'b0;
        motion_o.done <= ~err_en_i;
        motion_o.err  <= err_en_i;
        motion_o.code <= err_en_i ? err_code_i : 16'h0000;
      end
    end
  end
endmodule : motion_side_model

// ==== tb/positioning_table_entry_decoder_bench.sv ====
// Self-checking bench for the positioning table sequencer
`timescale 1ns/100ps
module positioning_table_entry_decoder_bench;
  import table_seq_pkg::*;
  typedef struct packed {logic [31:0] d; logic [31:0] m; logic e;} rd_note_s;
  typedef struct packed {motion_cmd_s c; logic a;} cmd_note_s;
  localparam logic [6:0] OPS [14] = '{7'h00, 7'h01, 7'h04, 7'h09, 7'h1c, 7'h1d, 7'h1e,
                                      7'h1f, 7'h47, 7'h49, 7'h4c, 7'h5a, 7'h5b, 7'h5c};
  // ----
  // Signals
  // ----
  logic        clk_i = 1'b0;
  logic        srst_i = 1'b1;
  apb_req_s    apb = '0;
  motion_rsp_s mrsp;
  motion_cmd_s cmd_o;
  logic [31:0] prdata_o;
  logic        pready_o, pslverr_o, cmd_valid_o, mcode_active_o;
  logic [7:0]  dly = 8'h01;
  logic        err_en = 1'b0;
  logic [15:0] err_code = 16'h0000;
  logic [31:0] rd, p, s;
  int          failures = 0;
  int          comparisons = 0;
  rd_note_s    rd_q[$];
  cmd_note_s   cmd_q[$];

  positioning_table_entry_decoder dut (.clk_i(clk_i), .srst_i(srst_i), .apb_i(apb),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .cmd_valid_o(cmd_valid_o), .cmd_o(cmd_o), .motion_i(mrsp),
    .mcode_active_o(mcode_active_o));
  motion_side_model model (.clk_i(clk_i), .srst_i(srst_i), .cmd_valid_i(cmd_valid_o),
    .delay_i(dly), .err_en_i(err_en), .err_code_i(err_code), .motion_o(mrsp));

  initial forever #4 clk_i = ~clk_i;
  // ----
  // Checking and bus tasks
  // ----
  task automatic fail(input string msg);
    failures++;
    $display("unexpected at %0t: %s", $time, msg);
  endtask : fail

  task automatic finish_test;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : finish_test

  // Empty queue yields all ones, which no real answer matches
  task automatic check_rd(input logic [31:0] d, input logic e);
    rd_note_s n;
    comparisons++;
    n = rd_q.size() ? rd_q.pop_front() : '1;
    if ((d & n.m) !== (n.d & n.m) || e !== n.e) fail("bus answer");
  endtask : check_rd

  task automatic check_cmd(input motion_cmd_s c, input logic a);
    cmd_note_s n;
    comparisons++;
    n = cmd_q.size() ? cmd_q.pop_front() : '1;
    if ({c, a} !== n) fail("motion command");
  endtask : check_cmd

  always @(posedge clk_i) begin
    if (pready_o === 1'b1) check_rd(prdata_o, pslverr_o);
    if (cmd_valid_o === 1'b1) check_cmd(cmd_o, mcode_active_o);
  end

  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] wd,
                      input logic [31:0] ex, input logic [31:0] m, input logic e);
    int n;
    rd_q.push_back('{ex, m, e});
    @(posedge clk_i);
    apb <= '{1'b1, 1'b0, w, a, wd};
    @(posedge clk_i);
    apb.penable <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge clk_i);
      if (pready_o === 1'b1) break;
    end
    rd = prdata_o;
    apb <= '0;
    if (n == 20) begin
      fail("no ready");
      finish_test();
    end
  endtask : xfer

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, 32'h0, 32'h0, 1'b0);
  endtask : wr

  task automatic rdc(input logic [11:0] a, input logic [31:0] ex, input logic [31:0] m);
    xfer(1'b0, a, 32'h0, ex, m, 1'b0);
  endtask : rdc

  task automatic entry(input int i, input logic [31:0] c, input logic [31:0] ps,
                       input logic [31:0] sp, input logic [31:0] mc);
    wr(12'(i * 16), c);
    wr(12'(i * 16 + 4), ps);
    wr(12'(i * 16 + 8), sp);
    wr(12'(i * 16 + 12), mc);
  endtask : entry

  task automatic wait_st(input int b, input logic v);
    int n;
    for (n = 0; n < 300; n++) begin
      rdc(STATUS_ADDR, 32'h0, 32'h0);
      if (rd[b] === v) break;
    end
    if (n == 300) begin
      fail("status wait");
      finish_test();
    end
  endtask : wait_st

  // Start a run and wait until it has stopped
  task automatic run(input logic [6:0] st);
    wr(START_ADDR, {25'h0, st});
    wr(CTRL_ADDR, 32'h22);
    wait_st(0, 1'b0);
  endtask : run

  function automatic motion_cmd_s ex_cmd(input logic [6:0] op, input logic [31:0] ps,
                                         input logic [31:0] sp, input logic [31:0] s2);
    ex_cmd = '{op, 32'h0, 32'h0, s2};
    if (op inside {7'h00, 7'h01, 7'h04, 7'h1f, 7'h47, 7'h48, 7'h49, 7'h5c}) ex_cmd.pos = ps;
    if (op inside {7'h00, 7'h01, 7'h1f, 7'h47, 7'h48}) ex_cmd.speed = sp;
  endfunction : ex_cmd
  // ----
  // Sequence
  // ----
  initial begin
    repeat (100000) @(posedge clk_i);
    fail("run timeout");
    finish_test();
  end

  initial begin
    void'($urandom(32'h9bf6b4ed));
    repeat (6) @(posedge clk_i);
    srst_i <= 1'b0;
    p = $urandom();
    s = $urandom() | 32'h1;
    rdc(CTRL_ADDR, 32'h0, '1);
    rdc(PARAM_BASE, PARAM_DEFAULT, '1);
    wr(STATUS_ADDR, '1);
    rdc(STATUS_ADDR, 32'h0, '1);
    xfer(1'b1, 12'h900, '1, 32'h0, 32'h0, 1'b1);
    xfer(1'b0, 12'h900, 32'h0, 32'h0, '1, 1'b1);
    wr(12'h634, p);
    rdc(12'h634, p, '1);
    $display("test map done");
    wr(12'h014, p);
    wr(CTRL_ADDR, 32'h1);
    rdc(12'h014, 32'h0, '1);
    wr(12'hc04, p);
    wr(CTRL_ADDR, 32'h0);
    rdc(12'hc04, PARAM_DEFAULT, '1);
    wr(CTRL_ADDR, 32'h20);
    wr(12'h014, p);
    wr(12'hc04, p);
    wr(CTRL_ADDR, 32'h21);
    wr(CTRL_ADDR, 32'h20);
    rdc(12'h014, p, '1);
    rdc(12'hc04, p, '1);
    rdc(CTRL_ADDR, 32'h20, '1);
    $display("test mode done");
    for (int i = 0; i < 14; i++) begin
      p = $urandom();
      s = $urandom() | 32'h1;
      entry(i, {25'h0, OPS[i]} + ((i == 13) ? 32'h0c8 : 32'h0), p, s, 32'h0);
      cmd_q.push_back('{ex_cmd(OPS[i], p, s, 32'h0), 1'b0});
    end
    dly <= 8'($urandom_range(20, 1));
    run(7'h00);
    rdc(STATUS_ADDR, 32'h20, 32'h3f);
    $display("test codes done");
    entry(60, 32'h0, p, 32'h0, 32'h5);
    entry(61, 32'h48, p, s, 32'h9);
    entry(62, 32'h1, ~p, ~s, 32'h7);
    entry(63, 32'h9, p, s, 32'h2);
    entry(64, 32'h122, p, s, 32'h0);
    cmd_q.push_back('{ex_cmd(7'h48, p, s, ~s), 1'b0});
    cmd_q.push_back('{ex_cmd(7'h09, p, s, 32'h0), 1'b0});
    cmd_q.push_back('{ex_cmd(7'h5a, p, s, 32'h0), 1'b0});
    wr(START_ADDR, 32'h3c);
    wr(CTRL_ADDR, 32'h22);
    wait_st(2, 1'b1);
    repeat (10) @(posedge clk_i);
    rdc(STATUS_ADDR, 32'h0c, 32'h0c);
    rdc(MNUM_ADDR, 32'h07, 32'hff);
    wr(CTRL_ADDR, 32'h28);
    wait_st(0, 1'b0);
    rdc(STATUS_ADDR, 32'h20, 32'h3c);
    $display("test jog done");
    entry(70, 32'h0e7, p, s, 32'h96);
    cmd_q.push_back('{ex_cmd(7'h1f, p, s, 32'h0), 1'b1});
    dly <= 8'h60;
    wr(START_ADDR, 32'h46);
    wr(CTRL_ADDR, 32'h22);
    wait_st(2, 1'b1);
    rdc(MNUM_ADDR, 32'h32, 32'hff);
    wr(CTRL_ADDR, 32'h28);
    wait_st(0, 1'b0);
    rdc(STATUS_ADDR, 32'h20, 32'h3f);
    $display("test with-mode done");
    dly <= 8'h03;
    entry(80, 32'h080, p, s, 32'h0);
    entry(81, 32'h122, p, s, 32'h0);
    cmd_q.push_back('{ex_cmd(7'h1c, p, s, 32'h0), 1'b0});
    wr(START_ADDR, 32'h50);
    wr(CTRL_ADDR, 32'h22);
    wait_st(1, 1'b1);
    repeat (20) @(posedge clk_i);
    rdc(STATUS_ADDR, 32'h02, 32'h22);
    cmd_q.push_back('{ex_cmd(7'h5a, p, s, 32'h0), 1'b0});
    wr(CTRL_ADDR, 32'h22);
    wait_st(0, 1'b0);
    $display("test hold done");
    entry(90, 32'h37, p, s, 32'h0);
    entry(99, 32'h48, p, s, 32'h0);
    entry(95, 32'h0c9, p, s, 32'h0);
    run(7'h5a);
    rdc(ERR_ADDR, {16'h0, ERR_BAD_CODE}, 32'hffff);
    rdc(STATUS_ADDR, 32'h10, 32'h11);
    run(7'h64);
    rdc(ERR_ADDR, {16'h0, ERR_BAD_START}, 32'hffff);
    run(7'h63);
    rdc(ERR_ADDR, {16'h0, ERR_NO_SECOND}, 32'hffff);
    err_en <= 1'b1;
    err_code <= 16'h00a5;
    cmd_q.push_back('{ex_cmd(7'h01, p, s, 32'h0), 1'b0});
    run(7'h5f);
    rdc(ERR_ADDR, 32'h00a5, 32'hffff);
    $display("test errors done");
    err_en <= 1'b0;
    dly <= 8'h60;
    cmd_q.push_back('{ex_cmd(7'h01, p, s, 32'h0), 1'b0});
    wr(START_ADDR, 32'h5f);
    wr(CTRL_ADDR, 32'h22);
    repeat (20) @(posedge clk_i);
    wr(CTRL_ADDR, 32'h24);
    wait_st(0, 1'b0);
    rdc(STATUS_ADDR, 32'h0, 32'h31);
    $display("test stop done");
    comparisons++;
    if (cmd_q.size() != 0) fail("command missing");
    finish_test();
  end
endmodule : positioning_table_entry_decoder_bench
